// *** rtl/vtp_pattern_ctrl.sv ***
// Test pattern generator control with APB registers and a pixel stream output
//
// Function
// (RULE_01) A power-down bit for the loop-through transmitter, 1 powers it down, resets to 0.
// (RULE_02) Software sets the transmitter power-down bit before enabling the generator.
// (RULE_03) Control bits 7 to 4 select the fixed pattern and reset to one.
// (RULE_04) Codes 1 to 5 give white, black, red, green, blue, or their inverses.
// (RULE_05) Codes 6 to 13 give horizontal then vertical ramps from black, inverted from white.
// (RULE_06) Code 14 gives the custom colour from three level registers; 0 and 15 are reserved.
// (RULE_07) Ramp steps spread evenly across the active width or height.
// (RULE_08) The select field is ignored while auto advance is on.
// (RULE_09) Control bit 3 selects the compliance pattern over the select field.
// (RULE_10) Control bit 2 gives eight colour bars, white first, black last.
// (RULE_11) Control bit 1 reverses the four-band order to blue, cyan, yellow, red.
// (RULE_12) Control bit 0 enables the generator and resets to zero.
// (RULE_13) With auto advance on, the pattern moves on after a programmed frame count.
// (RULE_14) Priority is compliance, then bars, then the select field; the code puts the four bands of configuration bit 2 before the select field.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "vtp_defs.svh"

module vtp_pattern_ctrl
  import vtp_pkg::*;
#(
  parameter int ACT_W = 1920,
  parameter int ACT_H = 1080
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  output logic             loopTxPowerDown,
  output logic      [23:0] pixData,
  output logic             pixFrameStart,
  output logic             pixLineEnd,
  output logic             pixValid,
  input  wire logic        pixReady
);

  // ****************************************
  // Geometry
  // ****************************************
  // Ramps assume an active area of at least 256 pixels each way
  localparam logic [11:0] LAST_X = 12'(ACT_W - 1);
  localparam logic [11:0] LAST_Y = 12'(ACT_H - 1);
  localparam logic [12:0] W13    = 13'(ACT_W);
  localparam logic [12:0] H13    = 13'(ACT_H);
  localparam logic [12:0] STEP   = 13'h0100;

  vtp_state_s s;
  vtp_state_s next_s;

  logic        setupPh;
  logic        accessPh;
  logic [7:0]  regIdx;
  logic        hit;
  logic [7:0]  rdByte;
  logic        genOn;
  logic        push;
  logic        bufReady;
  logic [25:0] bufIn;
  logic [25:0] bufOut;
  logic [3:0]  curCode;
  vtp_src_e    src;
  logic [23:0] pixel;
  logic [23:0] fixedPix;
  logic [12:0] hSum;
  logic [12:0] vSum;
  logic        lineLast;
  logic        frameLast;
  logic [7:0]  frameGoal;

  // Expand a three-bit colour into full-scale channels
  function automatic logic [23:0] full(input logic [2:0] c);
    full = {{8{c[2]}}, {8{c[1]}}, {8{c[0]}}};
  endfunction : full

  // Apply a ramp level to the chosen channels
  function automatic logic [23:0] ramp(input logic [2:0] c, input logic [7:0] lv);
    ramp = {(c[2] ? lv : 8'h00), (c[1] ? lv : 8'h00), (c[0] ? lv : 8'h00)};
  endfunction : ramp

  // ****************************************
  // APB decode
  // ****************************************
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign regIdx   = paddr[9:2];
  assign pready   = 1'b1;
  assign prdata   = s.rdata;
  assign pslverr  = accessPh & ~hit;

  always_comb begin
    hit = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    unique case (regIdx)
      `VTP_IDX_LOOP, `VTP_IDX_CTRL, `VTP_IDX_CFG, `VTP_IDX_FTIME,
      `VTP_IDX_RED, `VTP_IDX_GREEN, `VTP_IDX_BLUE, `VTP_IDX_STATUS: begin
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rdByte = 8'h00;
    unique case (regIdx)
      `VTP_IDX_LOOP: begin
        rdByte = {7'h00, s.loopPd};
      end
      `VTP_IDX_CTRL: begin
        rdByte = s.ctrl;
      end
      `VTP_IDX_CFG: begin
        rdByte = {5'h00, s.cfg};
      end
      `VTP_IDX_FTIME: begin
        rdByte = s.frameTime;
      end
      `VTP_IDX_RED: begin
        rdByte = s.red;
      end
      `VTP_IDX_GREEN: begin
        rdByte = s.green;
      end
      `VTP_IDX_BLUE: begin
        rdByte = s.blue;
      end
      `VTP_IDX_STATUS: begin
        rdByte = {curCode, 3'h0, genOn};
      end
      default: begin
        rdByte = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Pattern selection
  // ****************************************
  // Generator runs only once the transmitter is powered down
  assign genOn = s.ctrl[`VTP_CTRL_EN] & s.loopPd; // see (RULE_12) see (RULE_02)
  assign loopTxPowerDown = s.loopPd; // see (RULE_01)

  // Auto advance overrides the select field
  assign curCode = s.cfg[`VTP_CFG_AUTO] ? s.scrollCode // see (RULE_08)
                 : s.ctrl[`VTP_CTRL_SEL_MSB:`VTP_CTRL_SEL_LSB]; // see (RULE_03)

  always_comb begin
    if (!genOn) begin
      src = SRC_OFF;
    end else if (s.ctrl[`VTP_CTRL_COMPL]) begin
      src = SRC_COMPLIANCE; // see (RULE_09) see (RULE_14)
    end else if (s.ctrl[`VTP_CTRL_BARS]) begin
      src = SRC_BARS; // see (RULE_10) see (RULE_14)
    end else if (s.cfg[`VTP_CFG_BANDS]) begin
      src = SRC_BANDS;
    end else begin
      src = SRC_FIXED; // see (RULE_14)
    end
  end

  always_comb begin
    fixedPix = 24'h000000;
    unique case (curCode)
      4'h1: fixedPix = full(3'b111); // see (RULE_04)
      4'h2: fixedPix = full(3'b000); // see (RULE_04)
      4'h3: fixedPix = full(3'b100); // see (RULE_04)
      4'h4: fixedPix = full(3'b010); // see (RULE_04)
      4'h5: fixedPix = full(3'b001); // see (RULE_04)
      4'h6: fixedPix = ramp(3'b111, s.hLev); // see (RULE_05)
      4'h7: fixedPix = ramp(3'b100, s.hLev); // see (RULE_05)
      4'h8: fixedPix = ramp(3'b010, s.hLev); // see (RULE_05)
      4'h9: fixedPix = ramp(3'b001, s.hLev); // see (RULE_05)
      4'hA: fixedPix = ramp(3'b111, s.vLev); // see (RULE_05)
      4'hB: fixedPix = ramp(3'b100, s.vLev); // see (RULE_05)
      4'hC: fixedPix = ramp(3'b010, s.vLev); // see (RULE_05)
      4'hD: fixedPix = ramp(3'b001, s.vLev); // see (RULE_05)
      4'hE: fixedPix = {s.red, s.green, s.blue}; // see (RULE_06)
      // Reserved codes give black, or white when inverted, rather than stale data
      default: fixedPix = 24'h000000; // see (RULE_06)
    endcase
    if (s.cfg[`VTP_CFG_INV]) begin
      fixedPix = ~fixedPix; // see (RULE_04) see (RULE_05)
    end
  end

  always_comb begin
    pixel = 24'h000000;
    unique case (src)
      SRC_OFF: begin
        pixel = 24'h000000;
      end
      SRC_COMPLIANCE: begin
        pixel = (s.x[0] ^ s.y[0]) ? 24'hAAAAAA : 24'h555555;
      end
      SRC_BARS: begin
        // Bar index is the top three bits of the horizontal level
        unique case (s.hLev[7:5])
          3'h0: pixel = full(3'b111); // see (RULE_10)
          3'h1: pixel = full(3'b110);
          3'h2: pixel = full(3'b011);
          3'h3: pixel = full(3'b010);
          3'h4: pixel = full(3'b101);
          3'h5: pixel = full(3'b100);
          3'h6: pixel = full(3'b001);
          3'h7: pixel = full(3'b000);
        endcase
      end
      SRC_BANDS: begin
        // Quadrants in order top left, top right, bottom left, bottom right
        unique case ({s.vLev[7], s.hLev[7]})
          2'h0: pixel = full(s.ctrl[`VTP_CTRL_REV] ? 3'b001 : 3'b110); // see (RULE_11)
          2'h1: pixel = full(3'b011);
          2'h2: pixel = full(s.ctrl[`VTP_CTRL_REV] ? 3'b110 : 3'b001); // see (RULE_11)
          2'h3: pixel = full(3'b100);
        endcase
      end
      SRC_FIXED: begin
        pixel = fixedPix;
      end
    endcase
  end

  // ****************************************
  // Output buffer
  // ****************************************
  assign lineLast  = (s.x == LAST_X);
  assign frameLast = lineLast && (s.y == LAST_Y);
  assign bufIn     = {(s.x == 12'h000) && (s.y == 12'h000), lineLast, pixel};
  assign push      = genOn & bufReady;

  vtp_pair_buf #(
    .WIDTH(26)
  ) u_buf (
    .clk     (clk),
    .reset   (reset),
    .inData  (bufIn),
    .inValid (genOn),
    .inReady (bufReady),
    .outData (bufOut),
    .outValid(pixValid),
    .outReady(pixReady)
  );

  assign pixFrameStart = bufOut[25];
  assign pixLineEnd    = bufOut[24];
  assign pixData       = bufOut[23:0];

  // ****************************************
  // Next state
  // ****************************************
  assign hSum      = {1'b0, s.hAcc} + STEP;
  assign vSum      = {1'b0, s.vAcc} + STEP;
  assign frameGoal = (s.frameTime == 8'h00) ? 8'h01 : s.frameTime;

  always_comb begin
    next_s = s;
    if (setupPh) begin
      // Refused addresses read as zero, whatever the index bits alias to
      next_s.rdata = hit ? {24'h000000, rdByte} : 32'h00000000;
    end
    if (accessPh && pwrite && hit) begin
      unique case (regIdx)
        `VTP_IDX_LOOP: next_s.loopPd = pwdata[`VTP_LOOP_PD]; // see (RULE_01)
        `VTP_IDX_CTRL: next_s.ctrl = pwdata[7:0]; // see (RULE_03) see (RULE_12)
        `VTP_IDX_CFG: next_s.cfg = pwdata[2:0];
        `VTP_IDX_FTIME: next_s.frameTime = pwdata[7:0];
        `VTP_IDX_RED: next_s.red = pwdata[7:0]; // see (RULE_06)
        `VTP_IDX_GREEN: next_s.green = pwdata[7:0]; // see (RULE_06)
        `VTP_IDX_BLUE: next_s.blue = pwdata[7:0]; // see (RULE_06)
        default: begin
        end
      endcase
    end
    if (!genOn) begin
      // Restart the raster so the next enable opens a fresh frame
      next_s.x        = 12'h000;
      next_s.y        = 12'h000;
      next_s.hAcc     = 12'h000;
      next_s.vAcc     = 12'h000;
      next_s.hLev     = 8'h00;
      next_s.vLev     = 8'h00;
      next_s.frameCnt = 8'h00;
    end else if (push) begin
      // Even steps: one level per ACT_W/256 pixels, no divider needed
      if (lineLast) begin
        next_s.x    = 12'h000;
        next_s.hAcc = 12'h000;
        next_s.hLev = 8'h00;
        if (s.y == LAST_Y) begin
          next_s.y    = 12'h000;
          next_s.vAcc = 12'h000;
          next_s.vLev = 8'h00;
        end else begin
          next_s.y = s.y + 12'h001;
          if (vSum >= H13) begin
            next_s.vAcc = 12'(vSum - H13); // see (RULE_07)
            next_s.vLev = s.vLev + 8'h01;
          end else begin
            next_s.vAcc = vSum[11:0];
          end
        end
      end else begin
        next_s.x = s.x + 12'h001;
        if (hSum >= W13) begin
          next_s.hAcc = 12'(hSum - W13); // see (RULE_07)
          next_s.hLev = s.hLev + 8'h01;
        end else begin
          next_s.hAcc = hSum[11:0];
        end
      end
      if (frameLast) begin
        if (s.cfg[`VTP_CFG_AUTO] && (s.frameCnt + 8'h01 >= frameGoal)) begin
          next_s.frameCnt = 8'h00;
          // Wraps over the defined codes only, skipping reserved ones
          next_s.scrollCode = (s.scrollCode == `VTP_SCROLL_LAST) ? `VTP_SCROLL_FIRST
                            : s.scrollCode + 4'h1; // see (RULE_13)
        end else if (s.cfg[`VTP_CFG_AUTO]) begin
          next_s.frameCnt = s.frameCnt + 8'h01; // see (RULE_13)
        end else begin
          next_s.frameCnt = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s            <= '0;
      s.loopPd     <= `VTP_LOOP_RST; // see (RULE_01)
      s.ctrl       <= `VTP_CTRL_RST; // see (RULE_03) see (RULE_12)
      s.cfg        <= `VTP_CFG_RST;
      s.frameTime  <= `VTP_FTIME_RST;
      s.red        <= `VTP_LEVEL_RST;
      s.green      <= `VTP_LEVEL_RST;
      s.blue       <= `VTP_LEVEL_RST;
      s.scrollCode <= `VTP_SCROLL_FIRST;
    end else begin
      s <= next_s;
    end
  end

endmodule : vtp_pattern_ctrl

`default_nettype wire

// *** rtl/vtp_defs.svh ***
// Register indexes, field positions and reset values of the test pattern control
`ifndef VTP_DEFS_SVH
`define VTP_DEFS_SVH

// ****************************************
// Register indexes (byte address = 4 x index)
// ****************************************
`define VTP_IDX_LOOP     8'h63
`define VTP_IDX_CTRL     8'h64
`define VTP_IDX_CFG      8'h65
`define VTP_IDX_FTIME    8'h6A
`define VTP_IDX_RED      8'h6B
`define VTP_IDX_GREEN    8'h6C
`define VTP_IDX_BLUE     8'h6D
`define VTP_IDX_STATUS   8'h6E

// ****************************************
// Field positions
// ****************************************
`define VTP_LOOP_PD      0
`define VTP_CTRL_SEL_MSB 7
`define VTP_CTRL_SEL_LSB 4
`define VTP_CTRL_COMPL   3
`define VTP_CTRL_BARS    2
`define VTP_CTRL_REV     1
`define VTP_CTRL_EN      0
`define VTP_CFG_AUTO     0
`define VTP_CFG_INV      1
`define VTP_CFG_BANDS    2

// ****************************************
// Reset values
// ****************************************
`define VTP_LOOP_RST     1'h0
`define VTP_CTRL_RST     8'h10
`define VTP_CFG_RST      3'h0
`define VTP_FTIME_RST    8'h3C
`define VTP_LEVEL_RST    8'h80
`define VTP_SCROLL_FIRST 4'h1
`define VTP_SCROLL_LAST  4'hE

`endif

// *** rtl/vtp_pkg.sv ***
// Types shared by the test pattern control block
package vtp_pkg;

  typedef enum logic [2:0] {
    SRC_OFF,
    SRC_COMPLIANCE,
    SRC_BARS,
    SRC_BANDS,
    SRC_FIXED
  } vtp_src_e;

  typedef struct packed {
    logic        loopPd;
    logic [7:0]  ctrl;
    logic [2:0]  cfg;
    logic [7:0]  frameTime;
    logic [7:0]  red;
    logic [7:0]  green;
    logic [7:0]  blue;
    logic [31:0] rdata;
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] hAcc;
    logic [11:0] vAcc;
    logic [7:0]  hLev;
    logic [7:0]  vLev;
    logic [7:0]  frameCnt;
    logic [3:0]  scrollCode;
  } vtp_state_s;

endpackage : vtp_pkg

// *** rtl/vtp_pair_buf.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module vtp_pair_buf #(
  parameter int WIDTH = 26
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wrPtr;
    logic                  rdPtr;
    logic [1:0]            count;
  } vtp_buf_s;

  vtp_buf_s s;
  vtp_buf_s next_s;
  logic     push;
  logic     pop;

  // ****************************************
  // Handshakes
  // ****************************************
  // Full is honest: a stalled reader holds inReady low
  assign inReady  = (s.count != 2'h2);
  assign outValid = (s.count != 2'h0);
  assign outData  = s.mem[s.rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr        = ~s.wrPtr;
    end
    if (pop) begin
      next_s.rdPtr = ~s.rdPtr;
    end
    if (push && !pop) begin
      next_s.count = s.count + 2'h1;
    end else if (pop && !push) begin
      next_s.count = s.count - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : vtp_pair_buf

`default_nettype wire

// *** verification/vtp_sink_model.sv ***
// Downstream pixel path model that accepts pixels, with optional random stalls
`timescale 1ns/100ps
`default_nettype none
module vtp_sink_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [23:0] pixData,
  input  wire logic        pixFrameStart,
  input  wire logic        pixLineEnd,
  input  wire logic        pixValid,
  output logic             pixReady = 1'b0,
  output logic      [23:0] firstPix,
  output logic      [23:0] endPix,
  output int               nFrames = 0,
  output logic             gotEnd = 1'b0
);
  // ****************************************
  // Acceptance
  // ****************************************
  // Random stalls keep the two-entry buffer filling up and draining
  always @(posedge clk) begin
    pixReady <= slow ? 1'($urandom_range(1)) : 1'b1;
    if (pixValid && pixReady) begin
      if (pixFrameStart) begin
        firstPix <= pixData;
        nFrames <= nFrames + 1;
        gotEnd <= 1'b0;
      end else if (pixLineEnd && !gotEnd) begin
        endPix <= pixData;
        gotEnd <= 1'b1;
      end
    end
  end
endmodule : vtp_sink_model
`default_nettype wire

// *** verification/vtp_pattern_ctrl_assertions.sv ***
// Port assertions of the test pattern control block
`timescale 1ns/100ps
`default_nettype none
module vtp_pattern_ctrl_assertions #(
  parameter int ACT_W = 1920,
  parameter int ACT_H = 1080
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        loopTxPowerDown,
  input wire logic [23:0] pixData,
  input wire logic        pixFrameStart,
  input wire logic        pixLineEnd,
  input wire logic        pixValid,
  input wire logic        pixReady
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic acc;
  assign acc = psel && penable;
  pready_high_a: assert property (pready)
    else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  unmapped_err_a: assert property (acc && paddr == 12'h1BC |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  rdata_upper_a: assert property (prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  loop_write_a: assert property (acc && pwrite && paddr == 12'h18C
    |=> loopTxPowerDown == $past(pwdata[0]))
    else $error("power-down bit not written");
  loop_hold_a: assert property (!(acc && pwrite && paddr == 12'h18C)
    |=> $stable(loopTxPowerDown))
    else $error("power-down bit changed");
  reset_quiet_a: assert property ($fell(reset) |-> !pixValid
    && !loopTxPowerDown && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  stall_hold_a: assert property (pixValid && !pixReady |=> pixValid && $stable(pixData)
    && $stable(pixFrameStart) && $stable(pixLineEnd))
    else $error("pixel lost in stall");
  power_lock_a: assert property ($rose(pixValid)
    |-> $past(loopTxPowerDown) || $past(loopTxPowerDown, 2))
    else $error("pixels while transmitter powered");
  start_late_a: assert property (acc && pwrite && paddr == 12'h190 && pwdata[0]
    && loopTxPowerDown && !pixValid |=> ##1 pixValid)
    else $error("generator start late");
endmodule : vtp_pattern_ctrl_assertions
bind vtp_pattern_ctrl vtp_pattern_ctrl_assertions #(.ACT_W(ACT_W), .ACT_H(ACT_H)) i_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .loopTxPowerDown(loopTxPowerDown), .pixData(pixData), .pixFrameStart(pixFrameStart),
  .pixLineEnd(pixLineEnd), .pixValid(pixValid), .pixReady(pixReady));
`default_nettype wire

// *** verification/vtp_pattern_ctrl_test.sv ***
// Self-checking bench of the test pattern control block
`timescale 1ns/100ps
`default_nettype none
module vtp_pattern_ctrl_test;
  // ****************************************
  // Bench
  // ****************************************
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b1;
  logic pready, pslverr, loopTxPowerDown, pixFrameStart, pixLineEnd, pixValid, pixReady;
  logic gotEnd, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [23:0] pixData, firstPix, endPix, cust;
  int nMismatch = 0, testsRun = 0, nFrames;
  // Smallest raster keeps one whole frame inside the run length
  vtp_pattern_ctrl #(.ACT_W(256), .ACT_H(256)) i_vtp_pattern_ctrl (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .loopTxPowerDown(loopTxPowerDown),
    .pixData(pixData), .pixFrameStart(pixFrameStart), .pixLineEnd(pixLineEnd),
    .pixValid(pixValid), .pixReady(pixReady));
  vtp_sink_model i_vtp_sink_model (.clk(clk), .slow(slow), .pixData(pixData),
    .pixFrameStart(pixFrameStart), .pixLineEnd(pixLineEnd), .pixValid(pixValid),
    .pixReady(pixReady), .firstPix(firstPix), .endPix(endPix), .nFrames(nFrames),
    .gotEnd(gotEnd));
  initial begin
    forever #20 clk = ~clk;
  end
  task finish_test;
    if (nMismatch == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    testsRun++;
    if (s !== e) begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Stops the generator and lets the buffer drain, so each run starts at pixel (0,0)
  task run(input logic [7:0] ctl, input logic [2:0] cfg);
    int n;
    int k;
    apb(1'b1, 12'h190, 32'h0);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (pixValid !== 1'b0 && k < 50);
    if (k >= 50) begin
      nMismatch++;
    end
    apb(1'b1, 12'h194, 32'(cfg));
    n = nFrames;
    apb(1'b1, 12'h190, 32'(ctl));
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!(nFrames != n && gotEnd === 1'b1) && k < 3000);
    if (k >= 3000) begin
      nMismatch++;
    end
  endtask : run
  task pix(input logic [23:0] es, input logic [23:0] ee);
    chk("first pixel", 32'(firstPix), 32'(es));
    chk("line end pixel", 32'(endPix), 32'(ee));
  endtask : pix
  function automatic logic [23:0] expPix(input logic [3:0] c, input logic v, input logic e);
    logic [7:0]  l;
    logic [23:0] m;
    l = (e && c >= 4'h6 && c <= 4'h9) ? 8'hFF : 8'h00;
    case (c)
      4'h1: m = 24'hFFFFFF;
      4'h3: m = 24'hFF0000;
      4'h4: m = 24'h00FF00;
      4'h5: m = 24'h0000FF;
      4'h6, 4'hA: m = {3{l}};
      4'h7, 4'hB: m = {l, 16'h0000};
      4'h8, 4'hC: m = {8'h00, l, 8'h00};
      4'h9, 4'hD: m = {16'h0000, l};
      4'hE: m = cust;
      default: m = 24'h000000;
    endcase
    return v ? ~m : m;
  endfunction : expPix
  initial begin
    static logic [11:0] ra [7] = '{12'h18C, 12'h190, 12'h194, 12'h1A8, 12'h1AC, 12'h1B0,
                                   12'h1B4};
    static logic [7:0]  rv [7] = '{8'h00, 8'h10, 8'h00, 8'h3C, 8'h80, 8'h80, 8'h80};
    logic [4:0]  i;
    int          n;
    rd = $urandom(32'h95F5F5A7);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int j = 0; j < 7; j++) begin
      apb(1'b0, ra[j], 32'h0);
      chk("reset value", rd, 32'(rv[j]));
    end
    apb(1'b0, 12'h1BC, 32'h0);
    chk("unmapped error", 32'(se), 32'h1);
    apb(1'b1, 12'h190, 32'h11);
    repeat (20) @(negedge clk);
    chk("pixels while powered", 32'(pixValid), 32'h0);
    apb(1'b1, 12'h18C, 32'h1);
    apb(1'b0, 12'h18C, 32'h0);
    chk("power-down bit", rd, 32'h1);
    chk("power-down pin", 32'(loopTxPowerDown), 32'h1);
    cust = 24'($urandom);
    apb(1'b1, 12'h1AC, 32'(cust[23:16]));
    apb(1'b1, 12'h1B0, 32'(cust[15:8]));
    apb(1'b1, 12'h1B4, 32'(cust[7:0]));
    i = 5'h0;
    do begin
      // Invert is configuration bit 1; auto advance stays off here
      run({i[3:0], 4'h1}, {1'b0, i[4], 1'b0});
      pix(expPix(i[3:0], i[4], 1'b0), expPix(i[3:0], i[4], 1'b1));
      i++;
    end while (i != 5'h0);
    run(8'h25, 3'h0);
    pix(24'hFFFFFF, 24'h000000);
    run(8'h2D, 3'h0);
    chk("compliance", 32'(firstPix == 24'hAAAAAA || firstPix == 24'h555555), 32'h1);
    chk("compliance", 32'(firstPix ^ endPix), 32'hFFFFFF);
    run(8'h21, 3'h4);
    pix(24'hFFFF00, 24'h00FFFF);
    run(8'h23, 3'h4);
    pix(24'h0000FF, 24'h00FFFF);
    run(8'h25, 3'h4);
    pix(24'hFFFFFF, 24'h000000);
    slow <= 1'b0;
    apb(1'b1, 12'h1A8, 32'h1);
    run(8'h51, 3'h1);
    chk("auto first", 32'(firstPix), 32'hFFFFFF);
    n = nFrames;
    for (int k = 0; k < 70000 && nFrames == n; k++) @(negedge clk);
    if (nFrames == n) begin
      nMismatch++;
    end
    chk("auto next", 32'(firstPix), 32'h0);
    apb(1'b0, 12'h1B8, 32'h0);
    chk("auto code", 32'(rd[7:4]), 32'h2);
    finish_test();
  end
  initial begin
    // About 100000 cycles: the full run needs roughly 86000
    #4000000;
    nMismatch++;
    finish_test();
  end
endmodule : vtp_pattern_ctrl_test
`default_nettype wire
